// ### core/cdb_bus_share.sv
// bus sharing between the processor's bus cycle engine and a four-channel
// single-byte transfer controller. assumes all inputs are synchronous to sys_clk_i.
`timescale 1ns/1ps
module cdb_bus_share #(
	parameter int NCH = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic supply_good_i,
	input wire logic wait_i,
	input wire logic int_req_i,
	input wire logic nmi_req_i,
	input wire logic cpu_go_i,
	input wire logic cpu_port_i,
	input wire logic cpu_write_i,
	input wire logic [cdb_pkg::ADDR_W-1:0] cpu_addr_i,
	input wire logic [cdb_pkg::DATA_W-1:0] cpu_wdata_i,
	input wire logic [NCH-1:0] chan_req_i,
	input wire logic chan_to_mem_i,
	input wire logic [cdb_pkg::ADDR_W-1:0] start_addr_i,
	input wire logic [7:0] byte_count_i,
	input wire logic start_load_i,
	input wire logic [cdb_pkg::DATA_W-1:0] data_i,
	output logic cpu_busy_o,
	output logic irq_taken_o,
	output logic [cdb_pkg::ADDR_W-1:0] addr_o,
	output logic addr_oe_o,
	output logic [cdb_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o,
	output logic memory_cycle_strobe_o,
	output logic port_cycle_strobe_o,
	output logic rd_strobe_o,
	output logic wr_strobe_o,
	output logic refresh_cycle_flag_o,
	output logic bus_request_in_o,
	output logic bus_grant_out_o,
	output logic [NCH-1:0] channel_acknowledge_out_o,
	output logic xfer_done_o
);
	import cdb_pkg::*;

	initial begin
		if (NCH < 1 || NCH > 8) $error("NCH out of range");
	end

	// ****************************************
	// processor side
	// ****************************************
	cdb_cpu_t cpu_ff, nxt_cpu;
	logic run_ff, nxt_run;
	logic port_ff, nxt_port, wr_ff, nxt_wr;
	logic [ADDR_W-1:0] caddr_ff, nxt_caddr;
	logic [DATA_W-1:0] cdata_ff, nxt_cdata;
	logic [6:0] rfa_ff, nxt_rfa;
	logic nmi_d_ff, nxt_nmi_d;
	logic irq_ff, nxt_irq;
	logic nmi_pend_ff, nxt_nmi_pend;
	logic hold_req;

	always_comb begin
		nxt_cpu = cpu_ff;
		nxt_run = run_ff | supply_good_i; // see RULE11
		nxt_port = port_ff;
		nxt_wr = wr_ff;
		nxt_caddr = caddr_ff;
		nxt_cdata = cdata_ff;
		nxt_rfa = rfa_ff;
		nxt_nmi_d = nmi_req_i;
		// edge is latched so an nmi arriving mid-cycle or in hold is not lost
		nxt_nmi_pend = nmi_pend_ff | (nmi_req_i && !nmi_d_ff);
		nxt_irq = 1'b0;
		if (run_ff) begin
			case (cpu_ff)
				CP_T1: begin
					// bus is released only between cycles, never mid-cycle
					if (hold_req) begin
						nxt_cpu = CP_HOLD; // see RULE3
					end else if (nxt_nmi_pend || int_req_i) begin
						nxt_cpu = CP_INTA; // see RULE12
						nxt_irq = 1'b1;
						nxt_nmi_pend = 1'b0;
					end else if (cpu_go_i) begin
						nxt_cpu = CP_T2;
						nxt_port = cpu_port_i;
						nxt_wr = cpu_write_i;
						nxt_caddr = cpu_addr_i;
						nxt_cdata = cpu_wdata_i;
					end
				end
				CP_T2: begin
					if (!wait_i) begin
						nxt_cpu = CP_T3; // see RULE6
					end
				end
				CP_T3: begin
					nxt_cpu = CP_REFRESH_CYCLE_FLAG;
				end
				CP_REFRESH_CYCLE_FLAG: begin
					nxt_rfa = rfa_ff + 7'h01;
					nxt_cpu = CP_T1; // see RULE9
				end
				CP_INTA: begin
					nxt_cpu = CP_T1;
				end
				CP_HOLD: begin
					if (!hold_req) begin
						nxt_cpu = CP_T1; // see RULE15
					end
				end
				default: nxt_cpu = CP_T1;
			endcase
		end else begin
			nxt_cpu = CP_T1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cpu_ff <= CP_T1;
			run_ff <= 1'b0;
			port_ff <= 1'b0;
			wr_ff <= 1'b0;
			caddr_ff <= ADDR_RST;
			cdata_ff <= 8'h00;
			rfa_ff <= 7'h00;
			nmi_d_ff <= 1'b0;
			nmi_pend_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			cpu_ff <= nxt_cpu;
			run_ff <= nxt_run;
			port_ff <= nxt_port;
			wr_ff <= nxt_wr;
			caddr_ff <= nxt_caddr;
			cdata_ff <= nxt_cdata;
			rfa_ff <= nxt_rfa;
			nmi_d_ff <= nxt_nmi_d;
			nmi_pend_ff <= nxt_nmi_pend;
			irq_ff <= nxt_irq;
		end
	end

	logic granted;
	assign granted = (cpu_ff == CP_HOLD);
	assign bus_grant_out_o = granted; // see RULE3
	assign irq_taken_o = irq_ff;
	assign cpu_busy_o = !run_ff || (cpu_ff != CP_T1);

	// ****************************************
	// transfer controller
	// ****************************************
	cdb_dma_t dma_ff, nxt_dma;
	logic [ADDR_W-1:0] daddr_ff, nxt_daddr;
	logic [7:0] cnt_ff, nxt_cnt;
	logic [NCH-1:0] ack_ff, nxt_ack;
	logic [DATA_W-1:0] latch_ff, nxt_latch;
	logic done_ff, nxt_done;
	logic [NCH-1:0] pick;

	// lowest channel wins; fixed priority trades fairness for simplicity
	always_comb begin
		pick = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (chan_req_i[i]) begin
				pick = '0;
				pick[i] = 1'b1;
			end
		end
	end

	always_comb begin
		nxt_dma = dma_ff;
		nxt_daddr = daddr_ff;
		nxt_cnt = cnt_ff;
		nxt_ack = ack_ff;
		nxt_latch = latch_ff;
		nxt_done = 1'b0;
		if (start_load_i && dma_ff == DM_IDLE) begin
			nxt_daddr = start_addr_i; // see RULE5
			nxt_cnt = byte_count_i;
		end
		case (dma_ff)
			DM_IDLE: begin
				if (run_ff && |chan_req_i && cnt_ff != CNT_RST) begin
					nxt_dma = DM_REQ; // see RULE2
					nxt_ack = pick;
				end
			end
			DM_REQ: begin
				if (granted) begin
					nxt_dma = DM_XFER; // see RULE13
				end
			end
			DM_XFER: begin
				if (!wait_i) begin
					nxt_latch = data_i; // see RULE4
					nxt_daddr = daddr_ff + 16'h0001; // see RULE5
					nxt_cnt = cnt_ff - 8'h01;
					nxt_dma = DM_DONE;
				end
			end
			DM_DONE: begin
				// single transfer mode: hand the bus back after each byte
				nxt_ack = '0;
				nxt_done = (cnt_ff == CNT_RST);
				nxt_dma = DM_IDLE; // see RULE15
			end
			default: nxt_dma = DM_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dma_ff <= DM_IDLE;
			daddr_ff <= ADDR_RST;
			cnt_ff <= CNT_RST;
			ack_ff <= '0;
			latch_ff <= 8'h00;
			done_ff <= 1'b0;
		end else begin
			dma_ff <= nxt_dma;
			daddr_ff <= nxt_daddr;
			cnt_ff <= nxt_cnt;
			ack_ff <= nxt_ack;
			latch_ff <= nxt_latch;
			done_ff <= nxt_done;
		end
	end

	assign hold_req = (dma_ff == DM_REQ) || (dma_ff == DM_XFER);
	assign bus_request_in_o = hold_req;
	assign xfer_done_o = done_ff;

	// ****************************************
	// shared bus drive
	// ****************************************
	logic dma_own, cpu_cyc, cpu_rf;
	assign dma_own = granted && (dma_ff == DM_XFER); // see RULE13
	assign cpu_cyc = !granted && (cpu_ff == CP_T2 || cpu_ff == CP_T3);
	assign cpu_rf = !granted && (cpu_ff == CP_REFRESH_CYCLE_FLAG);

	// ownership is exclusive because dma_own needs the grant and cpu terms forbid it
	always_comb begin
		addr_o = caddr_ff; // see RULE10
		addr_oe_o = cpu_cyc || cpu_rf || dma_own; // see RULE1
		data_o = cdata_ff;
		data_oe_o = cpu_cyc && wr_ff;
		memory_cycle_strobe_o = 1'b0;
		port_cycle_strobe_o = 1'b0;
		rd_strobe_o = 1'b0;
		wr_strobe_o = 1'b0;
		refresh_cycle_flag_o = cpu_rf; // see RULE9
		channel_acknowledge_out_o = granted ? ack_ff : '0; // see RULE14
		if (dma_own) begin
			addr_o = daddr_ff;
			// port read and memory write fire together in one pulse
			memory_cycle_strobe_o = 1'b1;
			port_cycle_strobe_o = 1'b1;
			rd_strobe_o = 1'b1;
			wr_strobe_o = 1'b1;
			data_o = latch_ff;
		end else if (cpu_rf) begin
			addr_o = {9'h000, rfa_ff};
			memory_cycle_strobe_o = 1'b1;
		end else if (cpu_cyc) begin
			memory_cycle_strobe_o = !port_ff; // see RULE7
			port_cycle_strobe_o = port_ff;
			rd_strobe_o = !wr_ff; // see RULE8
			wr_strobe_o = wr_ff;
		end
	end
	logic unused_dir;
	assign unused_dir = chan_to_mem_i;
endmodule

// ### core/cdb_pkg.sv
// package for the processor / transfer-controller bus sharing block
// assumes one 40 MHz clock and synchronous pins.
// How it works
// RULE1: only one master drives shared lines
// RULE2: requester holds bus request while wanting bus
// RULE3: processor answers request with bus grant
// RULE4: owner moves bytes between port and memory
// RULE5: address counter advances one per byte
// RULE6: wait input stretches current cycle until ready
// RULE7: memory and port strobes qualify the address
// RULE8: read and write strobes mark direction
// RULE9: refresh flag marks refresh cycles
// RULE10: sixteen address bits and eight data bits
// RULE11: reset held until supply good reported
// RULE12: interrupt requests divert processor to handling
// RULE13: controller drives only after hold granted
// RULE14: per-channel acknowledge names the served channel
// RULE15: release after last transfer, grant drops next
package cdb_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int NCHAN = 4;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	localparam logic [7:0] CNT_RST = 8'h00;
	// processor cycle phases; each memory or port cycle is T1 address latch, T2 and T3 strobe, then a refresh phase
	typedef enum logic [2:0] {
		CP_T1,
		CP_T2,
		CP_T3,
		CP_REFRESH_CYCLE_FLAG,
		CP_INTA,
		CP_HOLD
	} cdb_cpu_t;
	// transfer controller phases
	typedef enum logic [1:0] {
		DM_IDLE,
		DM_REQ,
		DM_XFER,
		DM_DONE
	} cdb_dma_t;
endpackage

// ### sim/cdb_asserts.sv
// checker on the ports of the bus sharing block
// assumes it is bound onto every cdb_bus_share instance
`timescale 1ns/1ps
module cdb_asserts #(
	parameter int NCH = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic wait_i,
	input wire logic nmi_req_i,
	input wire logic addr_oe_o,
	input wire logic memory_cycle_strobe_o,
	input wire logic port_cycle_strobe_o,
	input wire logic rd_strobe_o,
	input wire logic wr_strobe_o,
	input wire logic refresh_cycle_flag_o,
	input wire logic bus_request_in_o,
	input wire logic bus_grant_out_o,
	input wire logic [NCH-1:0] channel_acknowledge_out_o,
	input wire logic irq_taken_o
);
	wire ack = |channel_acknowledge_out_o;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req_up;
		$rose(bus_request_in_o);
	endsequence
	a_grant_answer: assert property (s_req_up |-> ##[1:8] bus_grant_out_o)
		else $error("grant late");
	a_grant_release: assert property ($fell(bus_request_in_o) |-> ##[0:1] !bus_grant_out_o)
		else $error("grant kept");
	a_cpu_released: assert property (
		bus_grant_out_o && !(rd_strobe_o && wr_strobe_o) |-> !addr_oe_o && !memory_cycle_strobe_o)
		else $error("two owners");
	a_ack_onehot: assert property (
		ack |-> $onehot(channel_acknowledge_out_o) && bus_grant_out_o) else $error("bad ack");
	a_wait_stretch: assert property (
		memory_cycle_strobe_o && wait_i && !refresh_cycle_flag_o |=> memory_cycle_strobe_o)
		else $error("wait ignored");
	a_strobe_qual: assert property (
		rd_strobe_o || wr_strobe_o |-> (memory_cycle_strobe_o || port_cycle_strobe_o) && addr_oe_o)
		else $error("unqualified strobe");
	a_refresh_pulse: assert property (
		refresh_cycle_flag_o |-> memory_cycle_strobe_o && !rd_strobe_o ##1 !refresh_cycle_flag_o)
		else $error("bad refresh");
	a_nmi_taken: assert property ($rose(nmi_req_i) |-> ##[1:12] irq_taken_o)
		else $error("nmi missed");
endmodule
bind cdb_bus_share cdb_asserts #(.NCH(NCH)) chk_u (.*);

// ### sim/cdb_periph.sv
// far side: channel requesters and a slow memory
// assumes the strobes and done pulse of cdb_bus_share
`timescale 1ns/1ps
module cdb_periph (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] want_i,
	input wire logic [1:0] stall_i,
	input wire logic strobe_i,
	input wire logic done_i,
	output logic [3:0] chan_req_o,
	output logic wait_o,
	output logic [7:0] data_o
);
	logic [3:0] req_ff, nxt_req;
	logic [2:0] cnt_ff, nxt_cnt;
	always_comb begin
		nxt_req = done_i ? 4'h0 : req_ff | want_i;
		nxt_cnt = strobe_i ? cnt_ff + 3'h1 : 3'h0;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		req_ff <= rst_i ? 4'h0 : nxt_req;
		cnt_ff <= rst_i ? 3'h0 : nxt_cnt;
	end
	assign chan_req_o = req_ff;
	assign wait_o = strobe_i && cnt_ff < {1'b0, stall_i};
	// unselected bus shows 5A xor the strobe count, never A5, so stale data never matches
	assign data_o = strobe_i ? 8'hA5 : {5'h00, cnt_ff} ^ 8'h5A;
endmodule

// ### sim/tb.sv
// bench for the bus sharing block
// assumes cdb_periph on the far side
`timescale 1ns/1ps
module tb;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, supply_good_i = 1'b0, int_req_i = 1'b0;
	logic nmi_req_i = 1'b0, cpu_go_i = 1'b0, cpu_port_i = 1'b0, cpu_write_i = 1'b0;
	logic start_load_i = 1'b0, chan_to_mem_i = 1'b1, wait_i, cpu_busy_o, irq_taken_o;
	logic addr_oe_o, data_oe_o, memory_cycle_strobe_o, port_cycle_strobe_o, rd_strobe_o;
	logic wr_strobe_o, refresh_cycle_flag_o, bus_request_in_o, bus_grant_out_o, xfer_done_o;
	logic [15:0] cpu_addr_i = 16'h0000, start_addr_i = 16'h0000, addr_o;
	logic [7:0] cpu_wdata_i = 8'h00, byte_count_i = 8'h00, data_i, data_o;
	logic [3:0] want = 4'h0, chan_req_i, channel_acknowledge_out_o, strb;
	logic [1:0] stall = 2'h0;
	int n_mismatch = 0, n_checks = 0, i;
	assign strb = {port_cycle_strobe_o, memory_cycle_strobe_o, rd_strobe_o, wr_strobe_o};
	cdb_bus_share dut (.*);
	cdb_periph far (.sys_clk_i, .rst_i, .want_i(want), .stall_i(stall),
		.strobe_i(memory_cycle_strobe_o | port_cycle_strobe_o), .done_i(xfer_done_o),
		.chan_req_o(chan_req_i), .wait_o(wait_i), .data_o(data_i));
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cpu_cycle(input logic p, w, input logic [15:0] a, input logic [1:0] s);
		@(posedge sys_clk_i);
		{cpu_go_i, cpu_port_i, cpu_write_i, cpu_addr_i} <= {1'b1, p, w, a};
		{cpu_wdata_i, stall} <= {~a[7:0], s};
		@(posedge sys_clk_i);
		cpu_go_i <= 1'b0;
		#1;
		chk("strobes", {p, !p, !w, w}, strb);
		chk("address", a, addr_o);
		chk("busy", 16'h0001, {15'h0000, cpu_busy_o});
		if (w) chk("write data", {8'h01, ~a[7:0]}, {7'h00, data_oe_o, data_o});
		for (i = 0; i < 12 && refresh_cycle_flag_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
		chk("cycles to refresh", {14'h0000, s} + 16'h0002, i[15:0]);
		@(posedge sys_clk_i) #1;
		chk("refresh length", 16'h0000, {14'h0000, refresh_cycle_flag_o, cpu_busy_o});
	endtask
	task automatic dma_two();
		@(posedge sys_clk_i);
		{start_addr_i, byte_count_i, start_load_i, stall} <= {16'hFFFF, 8'h02, 1'b1, 2'h1};
		@(posedge sys_clk_i);
		{start_load_i, want} <= {1'b0, 4'hC};
		@(posedge sys_clk_i);
		want <= 4'h0;
		for (int b = 0; b < 2; b++) begin
			for (i = 0; i < 12 && rd_strobe_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
			chk("ack", 16'h0014, {11'h000, bus_grant_out_o, channel_acknowledge_out_o});
			chk("all strobes", 16'h000F, {12'h000, strb});
			chk("byte address", 16'hFFFF + b[15:0], addr_o);
			if (b > 0) chk("moved byte", 16'h00A5, {7'h00, data_oe_o, data_o});
			@(posedge sys_clk_i) #1;
			chk("stretched", 16'h000F, {12'h000, strb});
			for (i = 0; i < 12 && rd_strobe_o === 1'b1; i++) @(posedge sys_clk_i) #1;
		end
		for (i = 0; i < 12 && bus_grant_out_o === 1'b1; i++) @(posedge sys_clk_i) #1;
		chk("done pulse", 16'h0001, {15'h0000, xfer_done_o});
		@(posedge sys_clk_i) #1;
		chk("released", 16'h0000, {14'h0000, bus_request_in_o, chan_req_i != 4'h0});
	endtask
	task automatic nmi_mid();
		@(posedge sys_clk_i);
		{cpu_go_i, cpu_port_i, cpu_write_i, stall} <= {1'b1, 1'b0, 1'b0, 2'h3};
		@(posedge sys_clk_i);
		{cpu_go_i, nmi_req_i} <= 2'b01;
		@(posedge sys_clk_i);
		nmi_req_i <= 1'b0;
		for (i = 0; i < 16 && irq_taken_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
		chk("late nmi", 16'h0001, {15'h0000, irq_taken_o});
	endtask
	task automatic take_irq(input logic m);
		@(posedge sys_clk_i);
		{nmi_req_i, int_req_i} <= {m, !m};
		for (i = 0; i < 16 && irq_taken_o !== 1'b1; i++) @(posedge sys_clk_i) #1;
		chk("irq taken", 16'h0001, {15'h0000, irq_taken_o});
		@(posedge sys_clk_i);
		{nmi_req_i, int_req_i} <= 2'b00;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk("reset quiet", 16'h0000, {10'h000, addr_oe_o, bus_grant_out_o, strb});
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(posedge sys_clk_i);
		supply_good_i <= 1'b1;
		cpu_cycle(1'b0, 1'b0, 16'h8001, 2'h2);
		cpu_cycle(1'b1, 1'b1, 16'h00FE, 2'h0);
		dma_two();
		take_irq(1'b1);
		take_irq(1'b0);
		nmi_mid();
		give_verdict();
	end
endmodule
